// >>> rtl/cvr_change_det.sv
// Purpose: synchronise comparator outputs and detect change against a latch
// Assumes: raw comparator levels are asynchronous to hclk
// Notes:   result is the synchronised level read back by software
`timescale 1ns/1ps
module cvr_change_det
   import cvr_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   cvr_cmp_if.det    cmp
);
   typedef struct packed
   {
      logic [1:0] meta;
      logic [1:0] sync;
      logic [1:0] last;
   } cvr_det_s;

   cvr_det_s st_r;
   cvr_det_s st_nxt;

   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.meta = cmp.raw;
      st_nxt.sync = st_r.meta;
      // access to the control register ends the mismatch
      if (cmp.recapture)
      begin
         st_nxt.last = st_r.sync;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign cmp.result   = st_r.sync;
   assign cmp.mismatch = (st_r.sync != st_r.last);
endmodule : cvr_change_det

// >>> rtl/cvr_cmp_if.sv
// Purpose: carries comparator results between the top and change detector
// Assumes: single clock domain
// Notes:   recapture is a one-cycle pulse
`timescale 1ns/1ps
interface cvr_cmp_if;
   logic [1:0] raw;
   logic       recapture;
   logic [1:0] result;
   logic       mismatch;
   modport ctrl (output raw, output recapture, input result, input mismatch);
   modport det  (input raw, input recapture, output result, output mismatch);
endinterface : cvr_cmp_if

// >>> rtl/cvr_ctrl.sv
// Purpose: control and status of a dual comparator and resistor-ladder reference
// Assumes: AHB-Lite slave, zero wait states, word accesses only
// Notes:   read data is captured in the address phase
// Behaviour
// - mode 010 feeds the internal reference to both non-inverting inputs
// - both comparator results read back as read-only control bits
// - mode 110 puts raw comparator outputs on the two shared pins
// - direction bits still gate those two pin drivers
// - port data reads zero on pins used as analog inputs
// - any result change from the captured copy sets the change flag
// - flag clears only by writing zero; writing one sets it
// - interrupt needs flag and all three enables; flag sets regardless
// - change coinciding with a control register access may be missed
// - any control register read or write recaptures the results
// - a persisting mismatch keeps setting the flag
// - comparators run during sleep; enabled interrupt wakes the device
// - mode 111 powers off both comparators
// - waking from sleep leaves the control register unchanged
// - reset returns control register to zero, mode 000, comparators off
// - sixteen levels: level/24 high range, 1/4 plus level/32 low range
// - reset clears enable, pin output, range and level bits
// - waking from sleep leaves the reference register unchanged
// - reference reaches its pin only with direction input and output bit
// - reference settings never change comparator mode or state
// - result reads one when non-inverting input exceeds inverting input
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module cvr_ctrl
   import cvr_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // AHB-Lite slave
   input  wire logic                hsel,
   input  wire logic [ADDR_W-1:0]   haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   // analog comparator side
   input  wire logic                cmp1_level,
   input  wire logic                cmp2_level,
   output logic [2:0]               cmp_mode,
   output logic                     cmp_input_switch,
   output logic                     cmp_powered,
   output logic                     cmp_internal_ref,
   // reference ladder side
   output logic                     vref_enable,
   output logic                     vref_range_high,
   output logic [5:0]               vref_numerator,
   output logic                     vref_pin_connect,
   // port pins
   input  wire logic [4:0]          pin_in,
   output logic [4:0]               pin_out,
   output logic [4:0]               pin_oe,
   output logic [3:0]               pin_analog,
   // sleep and interrupt
   input  wire logic                sleep_mode,
   output logic                     wake_req,
   output logic                     cmp_irq
);
   typedef struct packed
   {
      logic        wr_pend;
      logic [9:0]  wr_idx;
      logic [31:0] rdata;
      logic [7:0]  irq_ctrl;
      logic        chg_flag;
      logic        chg_en;
      logic [3:0]  cmp_ctrl;
      logic [4:0]  portdir;
      logic [7:0]  ref_ctrl;
      logic [4:0]  portdata;
      logic        irq;
      logic        wake;
   } cvr_state_s;

   cvr_state_s st_r;
   cvr_state_s st_nxt;
   cvr_cmp_if  cmp ();

   // pins 0..3 that each mode turns into analog inputs
   function automatic logic [3:0] analog_mask(input logic [2:0] mode);
      logic [3:0] m;
      m = 4'h0;
      unique case (mode)
         CM_RESET,
         CM_THREE_IN,
         CM_FOUR_MUX,
         CM_INDEP:    m = 4'hF;
         CM_COMMON,
         CM_PIN_OUT:  m = 4'h7;
         CM_SINGLE:   m = 4'h6;
         CM_OFF:      m = 4'h0;
      endcase
      return m;
   endfunction : analog_mask

   function automatic logic [7:0] read_reg(input logic [9:0] idx,
                                           input cvr_state_s s,
                                           input logic [1:0] res,
                                           input logic [4:0] pins);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         IDX_IRQ_CTRL: v = s.irq_ctrl;
         IDX_PFLAG:    v[CHG_FLAG_BIT] = s.chg_flag;
         IDX_PENABLE:  v[CHG_EN_BIT] = s.chg_en;
         IDX_PORTDIR:  v = {3'h0, s.portdir};
         IDX_REF_CTRL: v = s.ref_ctrl;
         // results are status only, never stored from the bus
         IDX_CMP_CTRL: v = {res[1], res[0], 2'h0, s.cmp_ctrl};
         IDX_PORTDATA: v = {3'h0, pins & ~{1'b0, analog_mask(s.cmp_ctrl[2:0])}};
         default:      v = 8'h00;
      endcase
      return v;
   endfunction : read_reg

   logic       addr_take;
   logic [9:0] addr_idx;
   logic       wr_ctrl_acc;
   logic       rd_ctrl_acc;
   logic [7:0] wbyte;

   assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign addr_idx  = haddr[ADDR_W-1:2];
   assign wbyte     = hwdata[7:0];
   assign rd_ctrl_acc = addr_take && !hwrite && (addr_idx == IDX_CMP_CTRL);
   assign wr_ctrl_acc = st_r.wr_pend && (st_r.wr_idx == IDX_CMP_CTRL);

   // either access kind ends the mismatch
   assign cmp.raw       = {cmp2_level, cmp1_level};
   assign cmp.recapture = rd_ctrl_acc || wr_ctrl_acc;

   cvr_change_det u_det
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cmp     (cmp)
   );

   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.wr_pend = addr_take && hwrite;
      st_nxt.wr_idx  = addr_idx;
      if (addr_take && !hwrite)
      begin
         st_nxt.rdata = {24'h0, read_reg(addr_idx, st_r, cmp.result, pin_in)};
      end
      if (st_r.wr_pend)
      begin
         unique case (st_r.wr_idx)
            IDX_IRQ_CTRL: st_nxt.irq_ctrl = wbyte;
            IDX_PFLAG:    st_nxt.chg_flag = wbyte[CHG_FLAG_BIT];
            IDX_PENABLE:  st_nxt.chg_en = wbyte[CHG_EN_BIT];
            IDX_PORTDIR:  st_nxt.portdir = wbyte[4:0] & PORTDIR_WMASK;
            // reference writes touch only the reference register
            IDX_REF_CTRL: st_nxt.ref_ctrl = wbyte & REF_CTRL_WMASK;
            IDX_CMP_CTRL: st_nxt.cmp_ctrl = wbyte[3:0] & CMP_CTRL_WMASK[3:0];
            IDX_PORTDATA: st_nxt.portdata = wbyte[4:0];
            default:      st_nxt.portdata = st_r.portdata;
         endcase
      end
      // a change seen in an access cycle is dropped, an accepted race;
      // set still beats a software clear otherwise
      if (cmp.mismatch && !cmp.recapture)
      begin
         st_nxt.chg_flag = 1'b1;
      end
      st_nxt.irq  = st_nxt.chg_flag && st_nxt.chg_en && st_nxt.irq_ctrl[PER_EN_BIT]
                    && st_nxt.irq_ctrl[GLB_EN_BIT];
      // wake does not need the global enable
      st_nxt.wake = sleep_mode && st_nxt.chg_flag && st_nxt.chg_en
                    && st_nxt.irq_ctrl[PER_EN_BIT];
   end

   // sleep has no path into the register state, so wake keeps contents
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r          <= '0;
         st_r.irq_ctrl <= IRQ_CTRL_RST;
         st_r.chg_flag <= PFLAG_RST[CHG_FLAG_BIT];
         st_r.chg_en   <= PENABLE_RST[CHG_EN_BIT];
         st_r.cmp_ctrl <= CMP_CTRL_RST[3:0];
         st_r.portdir  <= PORTDIR_RST;
         st_r.ref_ctrl <= REF_CTRL_RST;
         st_r.portdata <= PORTDATA_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   logic [3:0] vr_level;
   assign vr_level = st_r.ref_ctrl[3:0];

   // pin drivers: raw comparator paths bypass the flops on purpose,
   // pins must show the unsynchronised level
   always_comb
   begin
      pin_out = st_r.portdata;
      if (st_r.cmp_ctrl[2:0] == CM_PIN_OUT)
      begin
         pin_out[CMP1_PIN] = cmp1_level;
         pin_out[CMP2_PIN] = cmp2_level;
      end
   end

   assign pin_oe           = ~st_r.portdir;
   assign pin_analog       = analog_mask(st_r.cmp_ctrl[2:0]);
   assign cmp_mode         = st_r.cmp_ctrl[2:0];
   assign cmp_input_switch = st_r.cmp_ctrl[INSW_BIT];
   // mode 000 holds them off too, which covers the reset interval
   assign cmp_powered      = (st_r.cmp_ctrl[2:0] != CM_OFF)
                             && (st_r.cmp_ctrl[2:0] != CM_RESET);
   assign cmp_internal_ref = (st_r.cmp_ctrl[2:0] == CM_FOUR_MUX);
   assign vref_enable      = st_r.ref_ctrl[REF_EN_BIT];
   assign vref_range_high  = st_r.ref_ctrl[REF_RNG_BIT];
   assign vref_numerator   = st_r.ref_ctrl[REF_RNG_BIT] ? {2'h0, vr_level}
                             : LOW_RANGE_BASE + {2'h0, vr_level};
   assign vref_pin_connect = st_r.portdir[VREF_PIN] && st_r.ref_ctrl[REF_OE_BIT];
   assign wake_req         = st_r.wake;
   assign cmp_irq          = st_r.irq;
   assign hrdata           = st_r.rdata;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
endmodule : cvr_ctrl

// >>> rtl/cvr_pkg.sv
// Purpose: constants for the comparator and reference control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   register indices are word indices; byte address is index * 4
package cvr_pkg;
   localparam int             ADDR_W          = 12;
   localparam logic [9:0]     IDX_IRQ_CTRL    = 10'h00B;
   localparam logic [9:0]     IDX_PFLAG       = 10'h00C;
   localparam logic [9:0]     IDX_CMP_CTRL    = 10'h01F;
   localparam logic [9:0]     IDX_PORTDIR     = 10'h085;
   localparam logic [9:0]     IDX_PENABLE     = 10'h08C;
   localparam logic [9:0]     IDX_REF_CTRL    = 10'h09F;
   localparam logic [9:0]     IDX_PORTDATA    = 10'h005;
   // field positions
   localparam int             GLB_EN_BIT      = 7;
   localparam int             PER_EN_BIT      = 6;
   localparam int             CHG_FLAG_BIT    = 6;
   localparam int             CHG_EN_BIT      = 6;
   localparam int             RES2_BIT        = 7;
   localparam int             RES1_BIT        = 6;
   localparam int             INSW_BIT        = 3;
   localparam int             REF_EN_BIT      = 7;
   localparam int             REF_OE_BIT      = 6;
   localparam int             REF_RNG_BIT     = 5;
   localparam int             VREF_PIN        = 2;
   localparam int             CMP1_PIN        = 3;
   localparam int             CMP2_PIN        = 4;
   // write masks and reset values
   localparam logic [7:0]     CMP_CTRL_WMASK  = 8'h0F;
   localparam logic [7:0]     REF_CTRL_WMASK  = 8'hEF;
   localparam logic [7:0]     PFLAG_WMASK     = 8'h40;
   localparam logic [7:0]     PENABLE_WMASK   = 8'h40;
   localparam logic [4:0]     PORTDIR_WMASK   = 5'h1F;
   localparam logic [7:0]     IRQ_CTRL_RST    = 8'h00;
   localparam logic [7:0]     PFLAG_RST       = 8'h00;
   localparam logic [7:0]     CMP_CTRL_RST    = 8'h00;
   localparam logic [4:0]     PORTDIR_RST     = 5'h1F;
   localparam logic [7:0]     PENABLE_RST     = 8'h00;
   localparam logic [7:0]     REF_CTRL_RST    = 8'h00;
   localparam logic [4:0]     PORTDATA_RST    = 5'h00;
   // ladder fractions: numerator over 24 (high range) or 32 (low range)
   localparam logic [5:0]     LOW_RANGE_BASE  = 6'h08;
   localparam logic [1:0]     HTRANS_NONSEQ   = 2'h2;
   localparam logic [1:0]     HTRANS_SEQ      = 2'h3;

   typedef enum logic [2:0]
   {
      CM_RESET     = 3'b000,
      CM_THREE_IN  = 3'b001,
      CM_FOUR_MUX  = 3'b010,
      CM_COMMON    = 3'b011,
      CM_INDEP     = 3'b100,
      CM_SINGLE    = 3'b101,
      CM_PIN_OUT   = 3'b110,
      CM_OFF       = 3'b111
   } cvr_mode_e;
endpackage : cvr_pkg

// >>> tb/comparator_vref_control_test.sv
// Purpose: self-checking bench for cvr_ctrl
// Assumes: zero-wait slave, one byte register per word
// Notes:   expected values come from the register map only
`timescale 1ns/1ps
module comparator_vref_control_test;
   import cvr_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cmp1_level, cmp2_level;
   logic cmp_input_switch, cmp_powered, cmp_internal_ref, vref_enable, vref_range_high;
   logic vref_pin_connect, sleep_mode, wake_req, cmp_irq;
   logic [31:0] hwdata, hrdata;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize, cmp_mode;
   logic [5:0]  vref_numerator;
   logic [4:0]  pin_in, pin_out, pin_oe;
   logic [3:0]  pin_analog;
   int          errors, checks, cyc;
   assign hready = hreadyout;
   cvr_ctrl u_cvr_ctrl
   (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .hsel             (hsel),
      .haddr            (haddr),
      .htrans           (htrans),
      .hwrite           (hwrite),
      .hsize            (hsize),
      .hwdata           (hwdata),
      .hready           (hready),
      .hreadyout        (hreadyout),
      .hrdata           (hrdata),
      .hresp            (hresp),
      .cmp1_level       (cmp1_level),
      .cmp2_level       (cmp2_level),
      .cmp_mode         (cmp_mode),
      .cmp_input_switch (cmp_input_switch),
      .cmp_powered      (cmp_powered),
      .cmp_internal_ref (cmp_internal_ref),
      .vref_enable      (vref_enable),
      .vref_range_high  (vref_range_high),
      .vref_numerator   (vref_numerator),
      .vref_pin_connect (vref_pin_connect),
      .pin_in           (pin_in),
      .pin_out          (pin_out),
      .pin_oe           (pin_oe),
      .pin_analog       (pin_analog),
      .sleep_mode       (sleep_mode),
      .wake_req         (wake_req),
      .cmp_irq          (cmp_irq)
   );
   always #5 hclk = ~hclk;
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         errors++;
         print_verdict();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // idle cycle first so every change lands right after an edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata[7:0];
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
      @(negedge hclk);
   endtask : wr
   task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(n, e, q);
   endtask : rd
   task automatic t_reset();
      rd("cmp_ctrl", 12'h07C, 8'h00);
      rd("ref_ctrl", 12'h27C, 8'h00);
      rd("portdir", 12'h214, 8'h1F);
      rd("flag", 12'h030, 8'h00);
      rd("enable", 12'h230, 8'h00);
      rd("portdata", 12'h014, 8'h10);
      rd("unmapped", 12'h3FC, 8'h00);
   endtask : t_reset
   task automatic t_modes();
      wr(12'h230, 8'h00);
      wr(12'h07C, 8'hCA);
      chk("iref", 8'h01, {7'h0, cmp_internal_ref});
      chk("input switch", 8'h01, {7'h0, cmp_input_switch});
      rd("cmp_ctrl ro", 12'h07C, 8'h0A);
      wr(12'h07C, 8'h07);
      chk("powered", 8'h00, {7'h0, cmp_powered});
      wr(12'h27C, 8'hA6);
      chk("num over24", 8'h06, {2'h0, vref_numerator});
      chk("vref on", 8'h01, {7'h0, vref_enable});
      chk("mode kept", 8'h07, {5'h0, cmp_mode});
      wr(12'h27C, 8'h1F);
      chk("num over32", 8'h17, {2'h0, vref_numerator});
      chk("vref off", 8'h00, {7'h0, vref_enable});
      rd("ref_ctrl", 12'h27C, 8'h0F);
      wr(12'h27C, 8'h40);
      chk("vref pin", 8'h01, {7'h0, vref_pin_connect});
      wr(12'h214, 8'h1B);
      chk("vref pin off", 8'h00, {7'h0, vref_pin_connect});
   endtask : t_modes
   task automatic t_pins();
      wr(12'h07C, 8'h06);
      repeat (4) @(posedge hclk);
      wr(12'h214, 8'h07);
      @(posedge hclk);
      cmp1_level <= 1'b1;
      @(negedge hclk);
      chk("pins raw", 8'h08, {3'h0, pin_out[4:3], 3'h0});
      chk("pins oe", 8'h18, {3'h0, pin_oe});
      wr(12'h214, 8'h1F);
      chk("pins oe off", 8'h00, {3'h0, pin_oe});
      rd("results", 12'h07C, 8'h46);
   endtask : t_pins
   task automatic t_flag();
      wr(12'h030, 8'h00);
      rd("flag clear", 12'h030, 8'h00);
      @(posedge hclk);
      cmp2_level <= 1'b1;
      repeat (6) @(posedge hclk);
      rd("flag set", 12'h030, 8'h40);
      wr(12'h030, 8'h00);
      rd("flag persists", 12'h030, 8'h40);
      rd("cmp_ctrl", 12'h07C, 8'hC6);
      wr(12'h030, 8'h00);
      rd("flag ends", 12'h030, 8'h00);
      wr(12'h030, 8'h40);
      rd("flag soft", 12'h030, 8'h40);
   endtask : t_flag
   task automatic t_irq();
      chk("irq masked", 8'h00, {7'h0, cmp_irq});
      wr(12'h230, 8'h40);
      wr(12'h02C, 8'h40);
      chk("irq no gie", 8'h00, {7'h0, cmp_irq});
      @(posedge hclk);
      sleep_mode <= 1'b1;
      repeat (2) @(negedge hclk);
      chk("wake", 8'h01, {7'h0, wake_req});
      wr(12'h02C, 8'hC0);
      chk("irq on", 8'h01, {7'h0, cmp_irq});
      wr(12'h030, 8'h00);
      chk("irq off", 8'h00, {7'h0, cmp_irq});
      @(posedge hclk);
      sleep_mode <= 1'b0;
      rd("cmp_ctrl kept", 12'h07C, 8'hC6);
      rd("ref_ctrl kept", 12'h27C, 8'h40);
   endtask : t_irq
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   initial
   begin
      {hclk, hresetn, hsel, hwrite, cmp1_level, cmp2_level, sleep_mode} = 7'h00;
      {hwdata, haddr, htrans, errors, checks, cyc} = '0;
      hsize = 3'h2;
      pin_in = 5'h1F;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_modes();
      t_pins();
      t_flag();
      t_irq();
      print_verdict();
   end
endmodule : comparator_vref_control_test

// >>> tb/cvr_ctrl_sva.sv
// Purpose: port-level checks for cvr_ctrl
// Assumes: one clock, asynchronous active-low reset
// Notes:   pin mux checked at the edge; raw path is combinational
`timescale 1ns/1ps
module cvr_ctrl_sva
   import cvr_pkg::*;
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       cmp1_level,
   input wire logic       cmp2_level,
   input wire logic [2:0] cmp_mode,
   input wire logic       cmp_powered,
   input wire logic       cmp_internal_ref,
   input wire logic       vref_enable,
   input wire logic       vref_range_high,
   input wire logic [5:0] vref_numerator,
   input wire logic       vref_pin_connect,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [3:0] pin_analog,
   input wire logic       sleep_mode,
   input wire logic       wake_req
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence pin_mode_s;
      cmp_mode == 3'h6;
   endsequence
   sequence pins_raw_s;
      pin_out[3] == cmp1_level && pin_out[4] == cmp2_level;
   endsequence
   int_ref_a: assert property (cmp_internal_ref == (cmp_mode == 3'h2))
      else $error("internal reference select wrong");
   pin_raw_a: assert property (pin_mode_s |-> pins_raw_s)
      else $error("comparator pins not raw outputs");
   vref_pin_a: assert property (vref_pin_connect |-> !pin_oe[2])
      else $error("reference on a driven pin");
   power_a: assert property (cmp_powered == (cmp_mode != 3'h0 && cmp_mode != 3'h7))
      else $error("comparator power wrong");
   reset_mode_a: assert property (cmp_mode == 3'h0 |-> pin_analog == 4'hF)
      else $error("reset mode pins not analog");
   reset_vals_a: assert property ($rose(hresetn) |-> !cmp_powered && !vref_enable
      && !vref_range_high && !vref_pin_connect && cmp_mode == 3'h0)
      else $error("outputs not at reset state");
   ladder_hi_a: assert property (vref_range_high |-> vref_numerator <= 6'h0F)
      else $error("high range numerator out of range");
   ladder_lo_a: assert property (!vref_range_high |-> vref_numerator inside {[8:23]})
      else $error("low range numerator out of range");
   wake_sleep_a: assert property (wake_req |-> $past(sleep_mode))
      else $error("wake without sleep");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus response not zero-wait okay");
endmodule : cvr_ctrl_sva

bind cvr_ctrl cvr_ctrl_sva u_cvr_ctrl_sva
(
   .hclk             (hclk),
   .hresetn          (hresetn),
   .hreadyout        (hreadyout),
   .hresp            (hresp),
   .cmp1_level       (cmp1_level),
   .cmp2_level       (cmp2_level),
   .cmp_mode         (cmp_mode),
   .cmp_powered      (cmp_powered),
   .cmp_internal_ref (cmp_internal_ref),
   .vref_enable      (vref_enable),
   .vref_range_high  (vref_range_high),
   .vref_numerator   (vref_numerator),
   .vref_pin_connect (vref_pin_connect),
   .pin_out          (pin_out),
   .pin_oe           (pin_oe),
   .pin_analog       (pin_analog),
   .sleep_mode       (sleep_mode),
   .wake_req         (wake_req)
);
